// file: design/tlic_pkg.sv
// Package for the two-level interrupt acceptance block
package tlic_pkg;
    localparam int TLIC_NSRC = 7;
    localparam logic [7:0] TLIC_VBASE_RST = 8'h00;
    localparam logic [7:0] TLIC_VLOW_RST = 8'h00;
    localparam logic [4:0] TLIC_VLOW_MASK = 5'h1F;
    localparam int TLIC_STAT_TIE_BIT = 0;
    localparam int TLIC_STAT_RIE_BIT = 3;
    // Internal vector slot numbers, in priority order
    localparam logic [2:0] TLIC_SLOT_ASYNC_SERIAL_CHANNEL0 = 3'h0;
    localparam logic [2:0] TLIC_SLOT_ASCI1 = 3'h1;
    localparam logic [2:0] TLIC_SLOT_EXT1 = 3'h0;
    localparam logic [2:0] TLIC_SLOT_EXT2 = 3'h1;
    // Serial slots sit above the two external ones
    localparam logic [2:0] TLIC_SLOT_SER_OFS = 3'h6;
    localparam logic [1:0] TLIC_EXT0_VECTORED = 2'h2;
    localparam logic [15:0] TLIC_NMI_ADDR = 16'h0066;
    localparam logic [15:0] TLIC_TRAP_ADDR = 16'h0000;
    localparam logic [15:0] TLIC_MODE1_ADDR = 16'h0038;

    typedef enum {
        TLIC_SRC_TRAP,
        TLIC_SRC_NMI,
        TLIC_SRC_EXT_IRQ_LINE0,
        TLIC_SRC_EXT_IRQ_LINE1,
        TLIC_SRC_EXT_IRQ_LINE2,
        TLIC_SRC_SER0,
        TLIC_SRC_SER1,
        TLIC_SRC_NONE
    } tlic_src_t;

    typedef struct packed {
        logic full;
        logic overrun;
        logic parity;
        logic framing;
        logic tx_empty;
    } tlic_ser_ev_t;

    typedef struct packed {
        logic valid;
        logic [2:0] src;
        logic [15:0] addr;
        logic [7:0] data_vec_hi;
    } tlic_ack_t;

    function automatic logic [2:0] tlic_first(input logic [6:0] req);
        logic [2:0] idx;
        idx = 3'h7;
        for (int i = TLIC_NSRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction : tlic_first
endpackage : tlic_pkg

// file: design/tlic_serial_req.sv
// Request logic of one asynchronous serial channel
module tlic_serial_req
    import tlic_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire tlic_ser_ev_t ev,
    input wire logic [7:0] status_ctl,
    output logic req
);
    typedef struct packed {
        logic req;
    } tlic_sr_state_t;
    tlic_sr_state_t st, next_st;
    logic receive_irq_enable;
    logic transmit_irq_enable;
    logic rx_cond;

    always_comb begin
        receive_irq_enable = status_ctl[TLIC_STAT_RIE_BIT];
        transmit_irq_enable = status_ctl[TLIC_STAT_TIE_BIT];
        rx_cond = ev.full | ev.overrun | ev.parity | ev.framing;
        next_st = st;
        // Registered level request: drops on the clock edge after the cause is removed
        next_st.req = (receive_irq_enable & rx_cond) | (transmit_irq_enable & ev.tx_empty);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign req = st.req;

    a_rx_masked: assert property (@(posedge clk) disable iff (rst)
        !status_ctl[TLIC_STAT_RIE_BIT] && !(status_ctl[TLIC_STAT_TIE_BIT]
        && ev.tx_empty) |=> !req)
        else $error("masked receive raised request");
    a_tx_req: assert property (@(posedge clk) disable iff (rst)
        status_ctl[TLIC_STAT_TIE_BIT] && ev.tx_empty |=> req)
        else $error("transmit empty request missing");
    a_rx_req: assert property (@(posedge clk) disable iff (rst)
        status_ctl[TLIC_STAT_RIE_BIT] && (ev.full || ev.overrun || ev.parity
        || ev.framing) |=> req)
        else $error("receive request missing");
endmodule : tlic_serial_req

// file: design/tlic_prio.sv
// Fixed priority pick among pending requests
module tlic_prio
    import tlic_pkg::*;
(
    input wire logic [6:0] req,
    output logic [2:0] win,
    output logic any
);
    always_comb begin
        win = tlic_first(req);
        any = |req;
    end
endmodule : tlic_prio

// file: design/tlic_top.sv
// Two-level interrupt acceptance logic
module tlic_top
    import tlic_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic INSTR_BOUNDARY,
    input wire logic EXEC_ENABLE_INTERRUPTS,
    input wire logic EXEC_DISABLE_INTERRUPTS,
    input wire logic EXEC_RETURN_FROM_INTERRUPT,
    input wire logic WR_VECTOR_BASE,
    input wire logic WR_VECTOR_LOW,
    input wire logic WR_EXT_IRQ_CONTROL,
    input wire logic WR_STATUS0,
    input wire logic WR_STATUS1,
    input wire logic [7:0] WDATA,
    input wire logic [1:0] EXT0_MODE,
    input wire logic [7:0] EXT0_VECTOR_DATA,
    input wire logic NMI_REQ,
    input wire logic TRAP_REQ,
    input wire logic EXT_IRQ_LINE0_N,
    input wire logic EXT_IRQ_LINE1_N,
    input wire logic EXT_IRQ_LINE2_N,
    input wire tlic_ser_ev_t SER0_EV,
    input wire tlic_ser_ev_t SER1_EV,
    output logic GLOBAL_MASKABLE_ENABLE_FLAG,
    output logic SAVED_ENABLE_FLAG,
    output logic [7:0] VECTOR_BASE,
    output logic [7:0] VECTOR_LOW,
    output logic [2:0] EXT_IRQ_CONTROL,
    output logic [7:0] STATUS0_CTL,
    output logic [7:0] STATUS1_CTL,
    output logic [6:0] PENDING,
    output tlic_ack_t ACK,
    output logic END_OF_SERVICE
);
    typedef struct packed {
        logic global_maskable_enable_flag;
        logic saved_enable_flag;
        logic nmi_edge;
        logic nmi_prev;
        logic [7:0] vbase;
        logic [7:0] vlow;
        logic [2:0] ite;
        logic [7:0] serial_channel0_status_register;
        logic [7:0] stat1;
        tlic_ack_t ack;
        logic eos;
    } tlic_state_t;

    tlic_state_t st, next_st;
    logic ser0_req;
    logic ser1_req;
    logic [6:0] req;
    logic [2:0] win;
    logic any;

    tlic_serial_req u_ser0 (
        .clk(CLOCK),
        .rst(RST),
        .ev(SER0_EV),
        .status_ctl(st.serial_channel0_status_register),
        .req(ser0_req)
    );

    tlic_serial_req u_ser1 (
        .clk(CLOCK),
        .rst(RST),
        .ev(SER1_EV),
        .status_ctl(st.stat1),
        .req(ser1_req)
    );

    // Maskable requests need both enable levels
    always_comb begin
        req = '0;
        req[TLIC_SRC_TRAP] = TRAP_REQ;
        req[TLIC_SRC_NMI] = st.nmi_edge;
        req[TLIC_SRC_EXT_IRQ_LINE0] = st.global_maskable_enable_flag & st.ite[0] & !EXT_IRQ_LINE0_N;
        req[TLIC_SRC_EXT_IRQ_LINE1] = st.global_maskable_enable_flag & st.ite[1] & !EXT_IRQ_LINE1_N;
        req[TLIC_SRC_EXT_IRQ_LINE2] = st.global_maskable_enable_flag & st.ite[2] & !EXT_IRQ_LINE2_N;
        req[TLIC_SRC_SER0] = st.global_maskable_enable_flag & ser0_req;
        req[TLIC_SRC_SER1] = st.global_maskable_enable_flag & ser1_req;
    end

    tlic_prio u_prio (
        .req(req),
        .win(win),
        .any(any)
    );

    function automatic logic [15:0] int_addr(input logic [7:0] hi,
                                             input logic [7:0] lo,
                                             input logic [2:0] slot);
        logic [15:0] a;
        a = {hi, lo[7:5], slot, 2'b00};
        return a;
    endfunction : int_addr

    always_comb begin
        next_st = st;
        next_st.ack.valid = 1'b0;
        next_st.eos = EXEC_RETURN_FROM_INTERRUPT;
        // NMI is edge triggered; held until taken
        next_st.nmi_prev = NMI_REQ;
        if (NMI_REQ && !st.nmi_prev) begin
            next_st.nmi_edge = 1'b1;
        end
        if (WR_VECTOR_BASE) next_st.vbase = WDATA;
        if (WR_VECTOR_LOW) next_st.vlow = WDATA & ~{3'h0, TLIC_VLOW_MASK};
        if (WR_EXT_IRQ_CONTROL) next_st.ite = WDATA[2:0];
        if (WR_STATUS0) next_st.serial_channel0_status_register = WDATA;
        if (WR_STATUS1) next_st.stat1 = WDATA;
        if (EXEC_DISABLE_INTERRUPTS) begin
            next_st.global_maskable_enable_flag = 1'b0;
            next_st.saved_enable_flag = 1'b0;
        end
        if (EXEC_ENABLE_INTERRUPTS) begin
            next_st.global_maskable_enable_flag = 1'b1;
            next_st.saved_enable_flag = 1'b1;
        end
        if (INSTR_BOUNDARY && any) begin
            next_st.ack.valid = 1'b1;
            next_st.ack.src = win;
            next_st.ack.data_vec_hi = st.vbase;
            next_st.global_maskable_enable_flag = 1'b0;
            case (win)
                3'(TLIC_SRC_TRAP): begin
                    next_st.ack.addr = TLIC_TRAP_ADDR;
                end
                3'(TLIC_SRC_NMI): begin
                    next_st.ack.addr = TLIC_NMI_ADDR;
                    next_st.saved_enable_flag = st.global_maskable_enable_flag;
                    // A fresh edge in the taking cycle stays pending
                    next_st.nmi_edge = NMI_REQ && !st.nmi_prev;
                end
                3'(TLIC_SRC_EXT_IRQ_LINE0): begin
                    if (EXT0_MODE == TLIC_EXT0_VECTORED) begin
                        next_st.ack.addr = {st.vbase, EXT0_VECTOR_DATA};
                    end else begin
                        next_st.ack.addr = TLIC_MODE1_ADDR;
                    end
                end
                3'(TLIC_SRC_EXT_IRQ_LINE1): begin
                    next_st.ack.addr = int_addr(st.vbase, st.vlow,
                                                TLIC_SLOT_EXT1);
                end
                3'(TLIC_SRC_EXT_IRQ_LINE2): begin
                    next_st.ack.addr = int_addr(st.vbase, st.vlow,
                                                TLIC_SLOT_EXT2);
                end
                3'(TLIC_SRC_SER0): begin
                    next_st.ack.addr = int_addr(st.vbase, st.vlow,
                                                TLIC_SLOT_ASYNC_SERIAL_CHANNEL0 +
                                                TLIC_SLOT_SER_OFS);
                end
                3'(TLIC_SRC_SER1): begin
                    next_st.ack.addr = int_addr(st.vbase, st.vlow,
                                                TLIC_SLOT_ASCI1 +
                                                TLIC_SLOT_SER_OFS);
                end
                default: begin
                    next_st.ack.valid = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            st <= '0;
            st.vbase <= TLIC_VBASE_RST;
            st.vlow <= TLIC_VLOW_RST;
        end else begin
            st <= next_st;
        end
    end

    assign GLOBAL_MASKABLE_ENABLE_FLAG = st.global_maskable_enable_flag;
    assign SAVED_ENABLE_FLAG = st.saved_enable_flag;
    assign VECTOR_BASE = st.vbase;
    assign VECTOR_LOW = st.vlow;
    assign EXT_IRQ_CONTROL = st.ite;
    assign STATUS0_CTL = st.serial_channel0_status_register;
    assign STATUS1_CTL = st.stat1;
    assign PENDING = req;
    assign ACK = st.ack;
    assign END_OF_SERVICE = st.eos;

    // Acceptance is taken on one edge and answered on the next
    sequence s_take;
        INSTR_BOUNDARY && any;
    endsequence
    sequence s_answer;
        ACK.valid && !st.global_maskable_enable_flag;
    endsequence
    sequence s_nmi_rise;
        !NMI_REQ ##1 NMI_REQ;
    endsequence

    // Acceptance beats an enable instruction in the same cycle
    a_accept_clears: assert property (@(posedge CLOCK)
        disable iff (RST) s_take |=> s_answer)
        else $error("acceptance did not clear global flag");
    a_ei_sets: assert property (@(posedge CLOCK)
        disable iff (RST)
        EXEC_ENABLE_INTERRUPTS && !(INSTR_BOUNDARY && any)
        |=> st.global_maskable_enable_flag && st.saved_enable_flag)
        else $error("enable instruction failed");
    a_di_clears: assert property (@(posedge CLOCK)
        disable iff (RST)
        EXEC_DISABLE_INTERRUPTS && !EXEC_ENABLE_INTERRUPTS |=> !st.global_maskable_enable_flag)
        else $error("disable instruction failed");
    a_mask_gate: assert property (@(posedge CLOCK)
        disable iff (RST)
        !st.global_maskable_enable_flag |-> req[6:2] == 5'h00)
        else $error("maskable request with global flag off");
    a_no_boundary: assert property (@(posedge CLOCK)
        disable iff (RST)
        !INSTR_BOUNDARY |=> !ACK.valid)
        else $error("accepted off boundary");
    a_reset_off: assert property (@(posedge CLOCK)
        $past(RST) |-> !st.global_maskable_enable_flag && st.ite == 3'h0)
        else $error("maskable enabled after reset");
    a_vec_hi: assert property (@(posedge CLOCK)
        disable iff (RST)
        s_take ##0 win >= 3'h3 |=> ACK.addr[15:8] == $past(st.vbase))
        else $error("vector base not used");
    a_eos: assert property (@(posedge CLOCK)
        disable iff (RST)
        EXEC_RETURN_FROM_INTERRUPT |=> END_OF_SERVICE)
        else $error("end of service missing");
    a_prio_top: assert property (@(posedge CLOCK)
        disable iff (RST)
        req[TLIC_SRC_TRAP] |-> win == 3'(TLIC_SRC_TRAP))
        else $error("trap did not win");
    // Winner is pending and nothing above it is
    a_prio_order: assert property (@(posedge CLOCK)
        disable iff (RST)
        any |-> req[win] && (req & ((7'h01 << win) - 7'h01)) == 7'h00)
        else $error("lower priority request won");
    a_ack_hold: assert property (@(posedge CLOCK)
        disable iff (RST)
        !(INSTR_BOUNDARY && any) |=> $stable(ACK.src) && $stable(ACK.addr))
        else $error("answer fields moved without acceptance");
    a_nmi_latch: assert property (@(posedge CLOCK)
        disable iff (RST)
        s_nmi_rise |=> PENDING[TLIC_SRC_NMI])
        else $error("non-maskable edge not pending");
    a_ext0_vec: assert property (@(posedge CLOCK)
        disable iff (RST)
        s_take ##0 (win == 3'(TLIC_SRC_EXT_IRQ_LINE0)
        && EXT0_MODE == TLIC_EXT0_VECTORED)
        |=> ACK.addr == {$past(st.vbase), $past(EXT0_VECTOR_DATA)})
        else $error("vectored line 0 address wrong");
endmodule : tlic_top

// file: verification/tlic_cpu_model.sv
// CPU sequencer stand-in: instruction boundaries and return decoding
module tlic_cpu_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [1:0] gap,
    input wire logic eos,
    output logic boundary,
    output int eos_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt;
    // A gap above zero models slow multi-cycle instructions
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= 2'h0;
            boundary <= 1'b0;
            eos_seen <= 0;
        end else begin
            boundary <= run && (cnt == gap);
            cnt <= (cnt == gap) ? 2'h0 : cnt + 2'h1;
            if (eos) begin
                eos_seen <= eos_seen + 1;
            end
        end
    end
endmodule : tlic_cpu_model

// file: verification/tb.sv
// Self-checking bench of the interrupt acceptance block
module tb;
    import tlic_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, ibnd, ei, di, return_from_interrupt_instruction, wvb, wvl, wec, ws0, ws1, nmi, trap;
    logic ln0, ln1, ln2, run, flag, sflag, eos;
    logic [7:0] wd, e0v, vb, vl, rvb, rvl, st0, st1;
    logic [1:0] e0m, gap;
    logic [2:0] ectl;
    logic [6:0] pend;
    tlic_ser_ev_t ser0, ser1;
    tlic_ack_t ack;
    int mismatches, checks_done, cycles, eos_seen, seed, k;
    tlic_top tlic_top_inst (.CLOCK(clk), .RST(rst), .INSTR_BOUNDARY(ibnd),
        .EXEC_ENABLE_INTERRUPTS(ei), .EXEC_DISABLE_INTERRUPTS(di),
        .EXEC_RETURN_FROM_INTERRUPT(return_from_interrupt_instruction), .WR_VECTOR_BASE(wvb),
        .WR_VECTOR_LOW(wvl), .WR_EXT_IRQ_CONTROL(wec), .WR_STATUS0(ws0),
        .WR_STATUS1(ws1), .WDATA(wd), .EXT0_MODE(e0m),
        .EXT0_VECTOR_DATA(e0v), .NMI_REQ(nmi), .TRAP_REQ(trap),
        .EXT_IRQ_LINE0_N(ln0), .EXT_IRQ_LINE1_N(ln1), .EXT_IRQ_LINE2_N(ln2),
        .SER0_EV(ser0), .SER1_EV(ser1), .GLOBAL_MASKABLE_ENABLE_FLAG(flag),
        .SAVED_ENABLE_FLAG(sflag), .VECTOR_BASE(rvb), .VECTOR_LOW(rvl),
        .EXT_IRQ_CONTROL(ectl), .STATUS0_CTL(st0), .STATUS1_CTL(st1),
        .PENDING(pend), .ACK(ack), .END_OF_SERVICE(eos));
    tlic_cpu_model tlic_cpu_model_inst (.clk(clk), .rst(rst), .run(run),
        .gap(gap), .eos(eos), .boundary(ibnd), .eos_seen(eos_seen));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    // Ceiling well above the hundred or so cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e,
                       input string m);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %0t %s got %h want %h", $time, m, g, e);
        end
    endtask : chk
    function automatic logic [15:0] vaddr(input logic [2:0] slot);
        return {vb, vl[7:5], slot, 2'b00};
    endfunction : vaddr
    task automatic step;
        @(posedge clk);
        #1;
    endtask : step
    task automatic drive(input int sel, input logic v);
        case (sel)
            0: wvb = v;
            1: wvl = v;
            2: wec = v;
            3: ws0 = v;
            4: ws1 = v;
            5: ei = v;
            6: di = v;
            default: return_from_interrupt_instruction = v;
        endcase
    endtask : drive
    // One strobe stands for one edge; only that strobe is touched
    task automatic pulse(input int sel);
        drive(sel, 1'b1);
        step();
        drive(sel, 1'b0);
    endtask : pulse
    task automatic wr(input int sel, input logic [7:0] d);
        wd = d;
        pulse(sel);
    endtask : wr
    task automatic wait_ack(input logic [2:0] s, input logic [15:0] a);
        logic got;
        got = 1'b0;
        for (int i = 0; i < 40 && !got; i++) begin
            @(posedge clk);
            #1;
            if (ack.valid === 1'b1) got = 1'b1;
        end
        chk({15'h0000, got}, 16'h0001, "no acceptance");
        chk({13'h0000, ack.src}, {13'h0000, s}, "source");
        chk(ack.addr, a, "vector address");
        chk({15'h0000, flag}, 16'h0000, "flag after accept");
    endtask : wait_ack
    task automatic no_ack;
        logic got;
        got = 1'b0;
        repeat (12) begin
            @(posedge clk);
            #1;
            if (ack.valid !== 1'b0) got = 1'b1;
        end
        chk({15'h0000, got}, 16'h0000, "unexpected acceptance");
    endtask : no_ack
    initial begin
        {ei, di, return_from_interrupt_instruction, wvb, wvl, wec, ws0, ws1, nmi, trap} = 10'h000;
        {ln0, ln1, ln2} = 3'h7;
        ser0 = '0;
        ser1 = '0;
        {wd, e0v, e0m} = 18'h00000;
        seed = 32'hB4A5;
        gap = 2'($random(seed));
        run = 1'b1;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        step();
        chk({8'h00, st0 | st1 | rvb | rvl}, 16'h0000, "reset regs");
        chk({12'h000, flag, ectl}, 16'h0000, "reset enables");
        wr(2, 8'h07);
        chk({13'h0000, ectl}, 16'h0007, "line enables");
        ln0 = 1'b0;
        no_ack();
        trap = 1'b1;
        wait_ack(3'(TLIC_SRC_TRAP), TLIC_TRAP_ADDR);
        trap = 1'b0;
        nmi = 1'b1;
        wait_ack(3'(TLIC_SRC_NMI), TLIC_NMI_ADDR);
        chk({15'h0000, sflag}, 16'h0000, "saved flag");
        nmi = 1'b0;
        pulse(5);
        chk({14'h0000, flag, sflag}, 16'h0003, "both flags");
        wait_ack(3'(TLIC_SRC_EXT_IRQ_LINE0), TLIC_MODE1_ADDR);
        ln0 = 1'b1;
        pulse(5);
        pulse(6);
        chk({15'h0000, flag}, 16'h0000, "disable");
        vb = 8'($random(seed));
        vl = 8'($random(seed));
        wr(0, vb);
        wr(1, vl);
        chk({rvb, rvl}, {vb, vl & 8'hE0}, "vector regs");
        {ln1, ln2} = 2'b00;
        pulse(5);
        chk({9'h000, pend}, 16'h0018, "pending lines");
        wait_ack(3'(TLIC_SRC_EXT_IRQ_LINE1), vaddr(3'h0));
        chk({8'h00, ack.data_vec_hi}, {8'h00, vb}, "base byte");
        ln1 = 1'b1;
        pulse(5);
        wait_ack(3'(TLIC_SRC_EXT_IRQ_LINE2), vaddr(3'h1));
        ln2 = 1'b1;
        wr(3, 8'h08);
        chk({8'h00, st0}, 16'h0008, "channel 0 enables");
        // Each receive cause alone, with an idle edge between them
        for (k = 0; k < 4; k++) begin
            ser0 = tlic_ser_ev_t'(5'h10 >> k);
            pulse(5);
            wait_ack(3'(TLIC_SRC_SER0), vaddr(3'h6));
            ser0 = '0;
            step();
        end
        wr(4, 8'h01);
        chk({8'h00, st1}, 16'h0001, "channel 1 enables");
        ser1.tx_empty = 1'b1;
        pulse(5);
        wait_ack(3'(TLIC_SRC_SER1), vaddr(3'h7));
        wr(3, 8'h01);
        ser0.full = 1'b1;
        pulse(5);
        wait_ack(3'(TLIC_SRC_SER1), vaddr(3'h7));
        {ser0, ser1} = 10'h000;
        wr(2, 8'h00);
        ln0 = 1'b0;
        pulse(5);
        no_ack();
        // Vectored line 0: disable first so the enable edge takes nothing
        e0v = 8'($random(seed));
        e0m = TLIC_EXT0_VECTORED;
        pulse(6);
        wr(2, 8'h01);
        pulse(5);
        wait_ack(3'(TLIC_SRC_EXT_IRQ_LINE0), {vb, e0v});
        ln0 = 1'b1;
        rst = 1'b1;
        repeat (2) step();
        rst = 1'b0;
        step();
        chk({8'h00, st0 | st1 | rvb | rvl}, 16'h0000, "regs again");
        chk({12'h000, flag, ectl}, 16'h0000, "enables again");
        pulse(7);
        chk({15'h0000, eos}, 16'h0001, "end of service");
        step();
        chk(16'(eos_seen), 16'h0001, "return decoded");
        complete_run();
    end
endmodule : tb
